// file: design/lbvc_map.vh
// Register map and constants for the bias common-voltage config slice.
// Assumes inclusion by bare name from the design file.
`ifndef LBVC_MAP_VH
`define LBVC_MAP_VH

// ==================================================================
// Slave addresses and register offsets
`define LBVC_COMMON_VOLTAGE_CODE_SLAVE_ADDR 7'h28
`define LBVC_OFS_CEILING 8'h13
`define LBVC_OFS_FLOOR 8'h14
`define LBVC_OFS_SCRATCH 8'h15
`define LBVC_OFS_CONTROL 8'hff
`define LBVC_OFS_COMMON_VOLTAGE_CODE_LEVEL 8'h00
`define LBVC_OFS_COMMON_VOLTAGE_CODE_SEL 8'h02

// ==================================================================
// Field positions
`define LBVC_CTRL_TRIG_BIT 7
`define LBVC_CTRL_RSEL_BIT 0
`define LBVC_VSEL_BIT 7

// ==================================================================
// Reset values
`define LBVC_RST_CEILING 4'h7
`define LBVC_RST_FLOOR 4'h7
`define LBVC_RST_SCRATCH 8'h00
`define LBVC_RST_COMMON_VOLTAGE_CODE 7'h40

// ==================================================================
// Serial engine states
`define LBVC_ST_IDLE 3'h0
`define LBVC_ST_ADDR 3'h1
`define LBVC_ST_ACKA 3'h2
`define LBVC_ST_WR 3'h3
`define LBVC_ST_ACKW 3'h4
`define LBVC_ST_RD 3'h5
`define LBVC_ST_RACK 3'h6

`endif

// file: design/lbvc_regs.v
// Two-wire slave register slice: voltage limits, scratch byte, store
// control and the common-voltage calibrator at its own slave address.
// Assumes SCL/SDA arrive asynchronous and an external pull-up on SDA.
//
// Contract
// - Floor register at 14h reads and writes
// - Unimplemented bits ignore writes, read zero
// - Floor code 4 bits, drives analog floor
// - Scratch byte stored, read back, no effect
// - Control bit7 copies volatile to store, self-clears
// - Control bit0 picks volatile or stored reads
// - Calibrator at 28h, level 00h, selector 02h
// - 7-bit level code drives calibrator output
// - Selector register write-only, reads zero
// - Selector zero: writes both, reads initial
// - Selector one: writes working, reads working
// - Settings retained in nonvolatile store; rst_i here resets the store and the initial level to reset values
// - Ceiling register at 13h, 4-bit code
`timescale 1ns/1ps
`include "lbvc_map.vh"

module lbvc_regs #(
    parameter [6:0] MAIN_SLAVE_ADDR = 7'h20,
    parameter [15:0] NV_COPY_CYCLES = 16'd100
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // Two-wire serial pins
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    // Analog-facing codes
    output reg [3:0] common_voltage_code_floor_code_o,
    output reg [3:0] common_voltage_code_ceiling_code_o,
    output reg [6:0] common_voltage_code_o,
    // Store status
    output reg nv_busy_o
);

    // ==================================================================
    // Pin synchronisers
    reg [1:0] scl_sync_reg;
    reg [1:0] sda_sync_reg;
    reg scl_q_reg;
    reg sda_q_reg;
    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s & ~scl_q_reg;
    wire scl_fall = ~scl_s & scl_q_reg;
    wire start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    wire stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_q_reg <= scl_s;
            sda_q_reg <= sda_s;
        end
    end

    // ==================================================================
    // Register storage
    reg [3:0] ceiling_reg;
    reg [3:0] floor_reg;
    reg [7:0] scratch_reg;
    reg rsel_reg;
    reg [3:0] nv_ceiling_reg;
    reg [3:0] nv_floor_reg;
    reg [7:0] nv_scratch_reg;
    reg [6:0] initial_value_reg;
    reg vsel_reg;
    reg [15:0] copy_cnt_reg;

    // Serial engine state
    reg [2:0] state_reg;
    reg [7:0] shift_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] ptr_reg;
    reg first_reg;
    reg rw_reg;
    reg dev_common_voltage_code_reg;
    reg nack_reg;

    // ==================================================================
    // Read mux
    reg [7:0] rd_data;
    always @* begin
        rd_data = 8'h00;
        if (dev_common_voltage_code_reg) begin
            if (ptr_reg == `LBVC_OFS_COMMON_VOLTAGE_CODE_LEVEL)
                rd_data = {1'b0, vsel_reg ? common_voltage_code_o :
                                            initial_value_reg};
            // Selector and all else read zero
        end else begin
            case (ptr_reg)
                `LBVC_OFS_CEILING:
                    rd_data = {4'h0, rsel_reg ? nv_ceiling_reg :
                                                ceiling_reg};
                `LBVC_OFS_FLOOR:
                    rd_data = {4'h0, rsel_reg ? nv_floor_reg :
                                                floor_reg};
                `LBVC_OFS_SCRATCH:
                    rd_data = rsel_reg ? nv_scratch_reg : scratch_reg;
                `LBVC_OFS_CONTROL:
                    rd_data = {nv_busy_o, 6'h00, rsel_reg};
                default:
                    rd_data = 8'h00;
            endcase
        end
    end

    wire addr_hit_main = shift_reg[7:1] == MAIN_SLAVE_ADDR;
    wire addr_hit_common_voltage_code = shift_reg[7:1] == `LBVC_COMMON_VOLTAGE_CODE_SLAVE_ADDR;
    wire wr_byte = (state_reg == `LBVC_ST_WR) && scl_fall &&
                   (bit_cnt_reg == 4'h8) && !first_reg;
    wire copy_done = nv_busy_o && (copy_cnt_reg == NV_COPY_CYCLES - 16'd1);

    // ==================================================================
    // Register writes and store copy
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            ceiling_reg <= `LBVC_RST_CEILING;
            floor_reg <= `LBVC_RST_FLOOR;
            scratch_reg <= `LBVC_RST_SCRATCH;
            rsel_reg <= 1'b0;
            nv_busy_o <= 1'b0;
            nv_ceiling_reg <= `LBVC_RST_CEILING;
            nv_floor_reg <= `LBVC_RST_FLOOR;
            nv_scratch_reg <= `LBVC_RST_SCRATCH;
            initial_value_reg <= `LBVC_RST_COMMON_VOLTAGE_CODE;
            common_voltage_code_o <= `LBVC_RST_COMMON_VOLTAGE_CODE;
            vsel_reg <= 1'b0;
            copy_cnt_reg <= 16'h0000;
            common_voltage_code_floor_code_o <= `LBVC_RST_FLOOR;
            common_voltage_code_ceiling_code_o <= `LBVC_RST_CEILING;
        end else begin
            // Copy runs over a fixed time to mimic the store write
            if (nv_busy_o) begin
                copy_cnt_reg <= copy_cnt_reg + 16'd1;
                if (copy_done) begin
                    nv_ceiling_reg <= ceiling_reg;
                    nv_floor_reg <= floor_reg;
                    nv_scratch_reg <= scratch_reg;
                    nv_busy_o <= 1'b0;
                    copy_cnt_reg <= 16'h0000;
                end
            end
            if (wr_byte && dev_common_voltage_code_reg) begin
                if (ptr_reg == `LBVC_OFS_COMMON_VOLTAGE_CODE_LEVEL) begin
                    // Bit 7 is read-only; hosts are expected to write 0
                    common_voltage_code_o <= shift_reg[6:0];
                    if (!vsel_reg)
                        initial_value_reg <= shift_reg[6:0];
                end else if (ptr_reg == `LBVC_OFS_COMMON_VOLTAGE_CODE_SEL) begin
                    vsel_reg <= shift_reg[`LBVC_VSEL_BIT];
                end
            end else if (wr_byte) begin
                case (ptr_reg)
                    `LBVC_OFS_CEILING: ceiling_reg <= shift_reg[3:0];
                    `LBVC_OFS_FLOOR: floor_reg <= shift_reg[3:0];
                    `LBVC_OFS_SCRATCH: scratch_reg <= shift_reg;
                    `LBVC_OFS_CONTROL: begin
                        rsel_reg <= shift_reg[`LBVC_CTRL_RSEL_BIT];
                        // Set wins over a completing copy; zero is ignored
                        if (shift_reg[`LBVC_CTRL_TRIG_BIT]) begin
                            nv_busy_o <= 1'b1;
                            copy_cnt_reg <= 16'h0000;
                        end
                    end
                    default: ;
                endcase
            end
            common_voltage_code_floor_code_o <= floor_reg;
            common_voltage_code_ceiling_code_o <= ceiling_reg;
        end
    end

    // ==================================================================
    // Serial slave engine
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg <= `LBVC_ST_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            ptr_reg <= 8'h00;
            first_reg <= 1'b0;
            rw_reg <= 1'b0;
            dev_common_voltage_code_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (start_det) begin
            state_reg <= `LBVC_ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_o <= 1'b0;
        end else if (stop_det) begin
            state_reg <= `LBVC_ST_IDLE;
            sda_oe_o <= 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                `LBVC_ST_ADDR, `LBVC_ST_WR: begin
                    shift_reg <= {shift_reg[6:0], sda_s};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                `LBVC_ST_RD: bit_cnt_reg <= bit_cnt_reg + 4'h1;
                `LBVC_ST_RACK: nack_reg <= sda_s;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                `LBVC_ST_ADDR: begin
                    if (bit_cnt_reg == 4'h8) begin
                        if (addr_hit_main || addr_hit_common_voltage_code) begin
                            state_reg <= `LBVC_ST_ACKA;
                            sda_oe_o <= 1'b1;
                            rw_reg <= shift_reg[0];
                            dev_common_voltage_code_reg <= addr_hit_common_voltage_code;
                        end else begin
                            state_reg <= `LBVC_ST_IDLE;
                        end
                    end
                end
                `LBVC_ST_ACKA: begin
                    bit_cnt_reg <= 4'h0;
                    if (rw_reg) begin
                        state_reg <= `LBVC_ST_RD;
                        shift_reg <= rd_data;
                        sda_oe_o <= ~rd_data[7];
                        ptr_reg <= ptr_reg + 8'h01;
                    end else begin
                        state_reg <= `LBVC_ST_WR;
                        first_reg <= 1'b1;
                        sda_oe_o <= 1'b0;
                    end
                end
                `LBVC_ST_WR: begin
                    if (bit_cnt_reg == 4'h8) begin
                        state_reg <= `LBVC_ST_ACKW;
                        sda_oe_o <= 1'b1;
                        first_reg <= 1'b0;
                        if (first_reg)
                            ptr_reg <= shift_reg;
                        else
                            ptr_reg <= ptr_reg + 8'h01;
                    end
                end
                `LBVC_ST_ACKW: begin
                    state_reg <= `LBVC_ST_WR;
                    bit_cnt_reg <= 4'h0;
                    sda_oe_o <= 1'b0;
                end
                `LBVC_ST_RD: begin
                    if (bit_cnt_reg == 4'h8) begin
                        state_reg <= `LBVC_ST_RACK;
                        sda_oe_o <= 1'b0;
                    end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe_o <= ~shift_reg[6];
                    end
                end
                `LBVC_ST_RACK: begin
                    if (nack_reg) begin
                        state_reg <= `LBVC_ST_IDLE;
                    end else begin
                        state_reg <= `LBVC_ST_RD;
                        bit_cnt_reg <= 4'h0;
                        shift_reg <= rd_data;
                        sda_oe_o <= ~rd_data[7];
                        ptr_reg <= ptr_reg + 8'h01;
                    end
                end
                default: state_reg <= `LBVC_ST_IDLE;
            endcase
        end
    end

endmodule // lbvc_regs

// file: sim/lbvc_regs_monitor.sv
// Checker for the bias config slice, watching the slave's ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module lbvc_regs_chk #(
    parameter [15:0] NV_COPY_CYCLES = 16'd100
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // Serial pins
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o,
    // Codes and status
    input wire [3:0] common_voltage_code_floor_code_o,
    input wire [3:0] common_voltage_code_ceiling_code_o,
    input wire [6:0] common_voltage_code_o,
    input wire nv_busy_o
);
    // Slack of 4 cycles above the NV_COPY_CYCLES that busy stays high after its rise
    localparam int BUSY_MAX = NV_COPY_CYCLES + 4;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // ========
    // Assertions
    chk_floor_reset: assert property (
        $fell(rst_i) |-> common_voltage_code_floor_code_o == 4'h7 && !nv_busy_o)
        else $error("floor code not 7h after reset");
    chk_level_reset: assert property (
        $fell(rst_i) |-> common_voltage_code_o == 7'h40
            && common_voltage_code_ceiling_code_o == 4'h7)
        else $error("level or ceiling wrong after reset");
    chk_copy_ends: assert property (
        $rose(nv_busy_o) |-> ##[1:BUSY_MAX] !nv_busy_o)
        else $error("store copy never completed");
    chk_copy_holds: assert property (
        $rose(nv_busy_o) |-> nv_busy_o [*3])
        else $error("store copy ended too early");
    chk_open_drain: assert property (
        sda_o == 1'b0)
        else $error("data pin driven high");
    chk_floor_at_low: assert property (
        !$stable(common_voltage_code_floor_code_o) |-> !scl_i)
        else $error("floor code moved while clock high");
    chk_level_at_low: assert property (
        !$stable(common_voltage_code_o) |-> !scl_i)
        else $error("level code moved while clock high");
    chk_ack_at_low: assert property (
        $rose(sda_oe_o) |-> !scl_i)
        else $error("data drive began while clock high");
    chk_oe_quiet_high: assert property (
        scl_i [*4] |-> $stable(sda_oe_o))
        else $error("data drive changed while clock high");
    cover property ($fell(nv_busy_o));
    cover property ($rose(sda_oe_o));
    cover property (!$stable(common_voltage_code_o));
endmodule // lbvc_regs_chk

bind lbvc_regs lbvc_regs_chk #(.NV_COPY_CYCLES(NV_COPY_CYCLES)) chk_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .common_voltage_code_floor_code_o(common_voltage_code_floor_code_o),
    .common_voltage_code_ceiling_code_o(common_voltage_code_ceiling_code_o),
    .common_voltage_code_o(common_voltage_code_o), .nv_busy_o(nv_busy_o));

// file: sim/lbvc_host.sv
// Two-wire host model, 20 clocks a bit.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps

module lbvc_host (
    // Clock and resolved data line
    input wire clk_sys_i,
    input wire sda_i,
    // Pins driven by the host
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Phases of 5 and 10 cycles keep clear of the 3 the slave's synchroniser and edge detect need
    task automatic bit_io(input logic b, output logic got);
        sda_low_o <= ~b;
        tick(5);
        scl_o <= 1'b1;
        tick(10);
        got = sda_i;
        scl_o <= 1'b0;
        tick(5);
    endtask

    task automatic start;
        sda_low_o <= 1'b0;
        tick(5);
        scl_o <= 1'b1;
        tick(5);
        sda_low_o <= 1'b1;
        tick(5);
        scl_o <= 1'b0;
        tick(5);
    endtask

    task automatic stop;
        sda_low_o <= 1'b1;
        tick(5);
        scl_o <= 1'b1;
        tick(5);
        sda_low_o <= 1'b0;
        tick(5);
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic ackb,
                           output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ackb, ack);
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                      input logic [7:0] dat, output logic nak);
        logic [7:0] r;
        logic a0, a1, a2;
        start;
        byte_io({dev, 1'b0}, 1'b1, r, a0);
        byte_io(ptr, 1'b1, r, a1);
        byte_io(dat, 1'b1, r, a2);
        stop;
        nak = a0 | a1 | a2;
    endtask

    task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                      output logic [7:0] dat, output logic nak);
        logic [7:0] r;
        logic a0, a1, a2, a3;
        start;
        byte_io({dev, 1'b0}, 1'b1, r, a0);
        byte_io(ptr, 1'b1, r, a1);
        start;
        byte_io({dev, 1'b1}, 1'b1, r, a2);
        byte_io(8'hff, 1'b1, dat, a3);
        stop;
        nak = a0 | a1 | a2;
    endtask
endmodule // lbvc_host

// file: sim/lbvc_regs_tb.sv
// Bench for the bias config slice, driven through the host model.
// Assumes the default slave address and a short store copy.
`timescale 1ns/1ps

module lbvc_regs_tb;
    localparam logic [6:0] MAIN = 7'h20;
    localparam logic [6:0] CAL = 7'h28;
    logic clk_sys_i, rst_i, scl, sda_low, sda_o, sda_oe_o, nv_busy_o;
    logic [3:0] fl, ce;
    logic [6:0] lv;
    wire sda_line;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    // Pull-up wins unless some party pulls low
    assign sda_line = ~(sda_low | (sda_oe_o & ~sda_o));

    lbvc_regs #(.MAIN_SLAVE_ADDR(MAIN), .NV_COPY_CYCLES(16'd64)) uut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .common_voltage_code_floor_code_o(fl), .common_voltage_code_ceiling_code_o(ce),
        .common_voltage_code_o(lv), .nv_busy_o(nv_busy_o));
    lbvc_host host (.clk_sys_i(clk_sys_i), .sda_i(sda_line),
        .scl_o(scl), .sda_low_o(sda_low));

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            complete_run;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic w(input logic [6:0] d, input logic [7:0] p, v);
        logic n;
        host.wr(d, p, v, n);
        chk({7'h0, n}, 8'h00);
    endtask

    task automatic r(input logic [6:0] d, input logic [7:0] p, e);
        logic [7:0] v;
        logic n;
        host.rd(d, p, v, n);
        chk({7'h0, n}, 8'h00);
        chk(v, e);
    endtask

    task automatic test_reset;
        chk({4'h0, fl}, 8'h07);
        chk({1'b0, lv}, 8'h40);
        r(MAIN, 8'h14, 8'h07);
        r(MAIN, 8'h13, 8'h07);
        $display("test_reset done");
    endtask

    task automatic test_floor;
        logic n;
        w(MAIN, 8'h14, 8'hfa);
        r(MAIN, 8'h14, 8'h0a);
        w(MAIN, 8'h15, 8'ha5);
        r(MAIN, 8'h15, 8'ha5);
        chk({4'h0, fl}, 8'h0a);
        w(MAIN, 8'h13, 8'hf9);
        r(MAIN, 8'h13, 8'h09);
        chk({4'h0, ce}, 8'h09);
        r(MAIN, 8'h20, 8'h00);
        host.wr(7'h31, 8'h14, 8'h01, n);
        chk({7'h0, n}, 8'h01);
        r(MAIN, 8'h14, 8'h0a);
        $display("test_floor done");
    endtask

    task automatic test_calib;
        r(CAL, 8'h00, 8'h40);
        w(CAL, 8'h02, 8'h80);
        w(CAL, 8'h00, 8'h15);
        chk({1'b0, lv}, 8'h15);
        r(CAL, 8'h00, 8'h15);
        r(CAL, 8'h02, 8'h00);
        w(CAL, 8'h02, 8'h00);
        r(CAL, 8'h00, 8'h40);
        w(CAL, 8'h00, 8'h2a);
        chk({1'b0, lv}, 8'h2a);
        r(CAL, 8'h00, 8'h2a);
        $display("test_calib done");
    endtask

    task automatic test_store;
        int i;
        w(MAIN, 8'hff, 8'hff);
        chk({7'h0, nv_busy_o}, 8'h01);
        for (i = 0; i < 100 && nv_busy_o !== 1'b0; i++) @(posedge clk_sys_i);
        chk({7'h0, nv_busy_o}, 8'h00);
        r(MAIN, 8'hff, 8'h01);
        w(MAIN, 8'h14, 8'h03);
        w(MAIN, 8'h15, 8'h5a);
        w(MAIN, 8'h13, 8'h02);
        r(MAIN, 8'h14, 8'h0a);
        r(MAIN, 8'h15, 8'ha5);
        r(MAIN, 8'h13, 8'h09);
        chk({4'h0, fl}, 8'h03);
        chk({4'h0, ce}, 8'h02);
        w(MAIN, 8'hff, 8'h00);
        r(MAIN, 8'h14, 8'h03);
        $display("test_store done");
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        test_reset;
        test_floor;
        test_calib;
        test_store;
        complete_run;
    end
endmodule // lbvc_regs_tb
